// File: bench/flash_page_security_checker_tb.sv
// Self-checking bench for the flash page security checker.
// Assumes flash_store_model closes the reset loop and holds the lock byte.
`timescale 1ns/1ps
module flash_page_security_checker_tb;
    import flash_sec_pkg::*;
    localparam int         LIMIT = 4000;
    logic                  ref_clk = 1'b0;
    logic                  bench_rst = 1'b1;
    logic                  por_rst = 1'b1;
    logic                  store_load = 1'b1;
    logic [7:0]            store_val = 8'hFF;
    logic                  req_valid = 1'b0;
    logic                  req_from_debug = 1'b0;
    op_t                   req_op = OP_READ;
    logic [ADDR_W-1:0]     req_addr = 13'h0000;
    logic [ADDR_W-1:0]     pc_addr = 13'h0000;
    logic [7:0]            req_wdata = 8'hFF;
    logic [IRQ_N-1:0]      irq_raw = 8'h00;
    logic                  irq_enable = 1'b0;
    logic                  flash_busy = 1'b0;
    logic                  irq_ack = 1'b0;
    logic                  rst, ready, grant, drop, flash_reset_req;
    logic                  flash_error_flag, irq_req;
    logic [7:0]            lock_byte_in, lock_pages, lock_shadow;
    logic [IRQ_ID_W-1:0]   irq_id;
    int                    miscompares = 0;
    int                    comparisons = 0;
    int                    cycles = 0;

    always #4 ref_clk = ~ref_clk;

    flash_page_security_checker dut (
        .ref_clk, .rst, .por_rst, .lock_byte_in, .req_valid, .req_from_debug,
        .req_op, .req_addr, .req_wdata, .pc_addr, .irq_raw, .irq_enable,
        .flash_busy, .irq_ack, .ready, .grant, .drop, .flash_reset_req,
        .flash_error_flag, .lock_pages, .lock_shadow, .irq_req, .irq_id);

    flash_store_model partner (
        .ref_clk, .bench_rst, .store_load, .store_val, .grant,
        .flash_reset_req, .lock_shadow, .rst, .lock_byte_in);

    task automatic conclude();
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: timeout", $time);
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wait_ready();
        for (int n = 0; n < 30 && ready !== 1'b1; n++) begin
            @(negedge ref_clk);
        end
        chk({7'h00, ready}, 8'h01, "ready");
    endtask : wait_ready

    // One request, verdict judged in the cycle after it is taken
    task automatic request(input logic dbg, input op_t op,
                           input logic [12:0] addr, input logic [7:0] wd,
                           input logic [12:0] pc, input verdict_t exp);
        logic [7:0] want;
        wait_ready();
        want = (exp == V_GRANT) ? 8'h04 : (exp == V_DROP) ? 8'h02 : 8'h01;
        req_valid = 1'b1;
        req_from_debug = dbg;
        req_op = op;
        req_addr = addr;
        req_wdata = wd;
        pc_addr = pc;
        @(negedge ref_clk);
        req_valid = 1'b0;
        chk({5'h00, grant, drop, flash_reset_req}, want, "verdict");
        @(negedge ref_clk);
        if (exp == V_DROP) begin
            chk({7'h00, ready}, 8'h01, "ready after drop");
        end
        if (exp == V_RESET) begin
            wait_ready();
            chk({7'h00, flash_error_flag}, 8'h01, "error flag");
        end
    endtask : request

    task automatic device_reset(input logic load, input logic [7:0] b);
        store_load = load;
        store_val = b;
        bench_rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        store_load = 1'b0;
        bench_rst = 1'b0;
        wait_ready();
    endtask : device_reset

    task automatic unlocked_case();
        for (int i = 0; i < 3; i++) begin
            request(1'b1, op_t'(i), 13'h0600, 8'h5A, 13'h0000, V_GRANT);
            request(1'b0, op_t'(i), 13'h0600, 8'h5A, 13'h1C00, V_GRANT);
        end
        request(1'b1, OP_READ, LOCK_ADDR, 8'hFF, 13'h0000, V_GRANT);
        request(1'b0, OP_WRITE, 13'h1C10, 8'h00, 13'h0000, V_GRANT);
        request(1'b1, OP_ERASE, 13'h1C00, 8'hFF, 13'h0000, V_GRANT);
        request(1'b0, OP_ERASE, 13'h1C00, 8'hFF, 13'h0600, V_RESET);
    endtask : unlocked_case

    task automatic reserved_case();
        for (int i = 0; i < 3; i++) begin
            request(1'b1, op_t'(i), 13'h1E00, 8'h00, 13'h0000, V_DROP);
            request(1'b0, op_t'(i), 13'h1FFF, 8'h00, 13'h0000, V_RESET);
        end
    endtask : reserved_case

    task automatic locked_case();
        device_reset(1'b1, 8'hFD);
        chk(lock_pages, 8'hFD, "enforced");
        chk({7'h00, flash_error_flag}, 8'h00, "error flag");
        request(1'b1, OP_READ, 13'h03FF, 8'h00, 13'h0000, V_DROP);
        request(1'b1, OP_READ, 13'h0400, 8'h00, 13'h0000, V_GRANT);
        request(1'b1, OP_READ, LOCK_ADDR, 8'h00, 13'h0000, V_DROP);
        request(1'b1, OP_WRITE, 13'h1C00, 8'h00, 13'h0000, V_DROP);
        request(1'b0, OP_READ, 13'h0000, 8'h00, 13'h0A00, V_RESET);
        request(1'b0, OP_READ, 13'h0200, 8'h00, 13'h0100, V_GRANT);
        request(1'b0, OP_READ, LOCK_ADDR, 8'h00, 13'h0100, V_GRANT);
        request(1'b0, OP_WRITE, 13'h1C20, 8'h00, 13'h0A00, V_RESET);
        request(1'b0, OP_WRITE, LOCK_ADDR, 8'hF8, 13'h0100, V_RESET);
        request(1'b1, OP_WRITE, LOCK_ADDR, 8'hFF, 13'h0000, V_DROP);
        request(1'b0, OP_ERASE, 13'h1C00, 8'hFF, 13'h0100, V_RESET);
        request(1'b1, OP_ERASE, 13'h1C00, 8'hFF, 13'h0000, V_DROP);
        request(1'b0, OP_DEV_ERASE, 13'h0000, 8'hFF, 13'h0100, V_RESET);
        chk(lock_pages, 8'hFD, "enforced");
        request(1'b1, OP_DEV_ERASE, 13'h0000, 8'hFF, 13'h0000, V_GRANT);
        chk(lock_pages, 8'hFF, "enforced");
        chk(lock_shadow, 8'hFF, "stored");
        request(1'b1, OP_READ, 13'h0000, 8'h00, 13'h0000, V_GRANT);
    endtask : locked_case

    task automatic late_lock_case();
        device_reset(1'b1, 8'hFF);
        chk({7'h00, flash_error_flag}, 8'h00, "error flag");
        request(1'b0, OP_WRITE, LOCK_ADDR, 8'hFE, 13'h0000, V_GRANT);
        chk(lock_pages, 8'hFF, "enforced");
        chk(lock_shadow, 8'hFE, "stored");
        request(1'b1, OP_READ, 13'h0000, 8'h00, 13'h0000, V_GRANT);
        request(1'b1, OP_WRITE, LOCK_ADDR, 8'hFC, 13'h0000, V_DROP);
        device_reset(1'b0, 8'h00);
        chk(lock_pages, 8'hFE, "enforced");
        request(1'b1, OP_READ, 13'h01FF, 8'h00, 13'h0000, V_DROP);
        request(1'b1, OP_READ, 13'h0200, 8'h00, 13'h0000, V_GRANT);
    endtask : late_lock_case

    task automatic irq_case();
        logic [7:0] ids [3];
        ids = '{8'h03, 8'h05, 8'h06};
        irq_enable = 1'b0;
        flash_busy = 1'b1;
        irq_raw = 8'h20;
        @(negedge ref_clk);
        irq_raw = 8'h00;
        repeat (3) @(negedge ref_clk);
        chk({7'h00, irq_req}, 8'h00, "irq while busy");
        flash_busy = 1'b0;
        irq_enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({7'h00, irq_req}, 8'h01, "irq after busy");
        chk({5'h00, irq_id}, 8'h05, "irq id");
        flash_busy = 1'b1;
        @(negedge ref_clk);
        chk({7'h00, irq_req}, 8'h00, "irq held by busy");
        flash_busy = 1'b0;
        irq_raw = 8'h48;
        @(negedge ref_clk);
        irq_raw = 8'h00;
        @(negedge ref_clk);
        // Lowest index first, then the rest in turn
        for (int k = 0; k < 3; k++) begin
            chk({5'h00, irq_id}, ids[k], "irq order");
            irq_ack = 1'b1;
            @(negedge ref_clk);
            irq_ack = 1'b0;
            repeat (2) @(negedge ref_clk);
        end
        chk({7'h00, irq_req}, 8'h00, "irq drained");
    endtask : irq_case

    initial begin
        repeat (2) @(negedge ref_clk);
        por_rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        store_load = 1'b0;
        bench_rst = 1'b0;
        wait_ready();
        unlocked_case();
        reserved_case();
        locked_case();
        late_lock_case();
        irq_case();
        conclude();
    end
endmodule : flash_page_security_checker_tb

// File: bench/flash_store_model.sv
// Far-side model: system reset logic and the flash cell holding the lock byte.
// Assumes the bench preloads the cell while it holds its own reset.
`timescale 1ns/1ps
module flash_store_model (
    input  wire logic       ref_clk,         // System clock
    input  wire logic       bench_rst,       // Reset from the bench
    input  wire logic       store_load,      // Preload strobe
    input  wire logic [7:0] store_val,       // Preload value
    input  wire logic       grant,           // Access allowed
    input  wire logic       flash_reset_req, // Firmware violation
    input  wire logic [7:0] lock_shadow,     // Stored byte after access
    output logic            rst,             // Device reset
    output logic [7:0]      lock_byte_in     // Cell read at reset
);
    logic [1:0] hold_ff;
    logic [1:0] nxt_hold;
    logic [7:0] nxt_store;

    always_comb begin
        nxt_hold = (hold_ff != 2'h0) ? hold_ff - 2'h1 : 2'h0;
        if (flash_reset_req) begin
            nxt_hold = 2'h3;
        end
        nxt_store = lock_byte_in;
        if (store_load) begin
            nxt_store = store_val;
        end else if (grant) begin
            nxt_store = lock_shadow;
        end
    end

    always_ff @(posedge ref_clk or posedge bench_rst) begin
        if (bench_rst) begin
            hold_ff <= 2'h0;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    // Cell keeps its value through reset, like real flash
    always_ff @(posedge ref_clk) begin
        lock_byte_in <= nxt_store;
    end

    // Reset source never rewritten here
    // Three cycles of reset satisfy the two-edge minimum
    assign rst = bench_rst | (hold_ff != 2'h0);
endmodule : flash_store_model

// File: verilog/flash_page_security_checker.sv
// Access checker for program flash requests from debug port and firmware.
// Assumes lock_byte_in holds the stored lock byte while rst releases, and
// that the system turns flash_reset_req into a device reset.
`timescale 1ns/1ps
module flash_page_security_checker (
    input  wire logic                            ref_clk,  // System clock
    input  wire logic                            rst,      // Device reset
    input  wire logic                            por_rst,  // Power-on reset
    input  wire logic [7:0]                      lock_byte_in, // Stored byte
    input  wire logic                            req_valid,    // Request
    input  wire logic                            req_from_debug, // Source
    input  wire flash_sec_pkg::op_t              req_op,   // Operation
    input  wire logic [flash_sec_pkg::ADDR_W-1:0] req_addr, // Target
    input  wire logic [7:0]                      req_wdata, // Write data
    input  wire logic [flash_sec_pkg::ADDR_W-1:0] pc_addr, // Code address
    input  wire logic [flash_sec_pkg::IRQ_N-1:0] irq_raw,  // Irq events
    input  wire logic                            irq_enable, // Global en
    input  wire logic                            flash_busy, // Op running
    input  wire logic                            irq_ack,  // Served id
    output logic                                 ready,    // Accepting
    output logic                                 grant,    // Allowed
    output logic                                 drop,     // Debug refused
    output logic                                 flash_reset_req, // Reset
    output logic                                 flash_error_flag, // Flag
    output logic [7:0]                           lock_pages, // Enforced
    output logic [7:0]                           lock_shadow, // Stored
    output logic                                 irq_req,  // Irq request
    output logic [flash_sec_pkg::IRQ_ID_W-1:0]   irq_id    // Irq index
);
    import flash_sec_pkg::*;

    page_class_if tgt_if ();
    page_class_if pc_if ();

    page_classifier u_tgt_class (
        .pc (tgt_if.classifier)
    );

    page_classifier u_pc_class (
        .pc (pc_if.classifier)
    );

    state_t     state_ff, nxt_state;
    verdict_t   verdict;
    logic [7:0] lock_ff, nxt_lock;
    logic [7:0] shadow_ff, nxt_shadow;
    logic       grant_ff, drop_ff, reset_ff, ready_ff;
    logic       any_locked;
    logic       lock_write;
    logic       deny_is_reset;
    logic       take;

    assign tgt_if.addr     = req_addr;
    assign tgt_if.lock_val = lock_ff;
    assign pc_if.addr      = pc_addr;
    assign pc_if.lock_val  = lock_ff;

    assign any_locked = (lock_ff != LOCK_NONE);
    assign lock_write = (req_op == OP_WRITE) && (req_addr == LOCK_ADDR);
    assign take       = (state_ff == S_RUN) && req_valid;
    // Debug refusals are silent; firmware refusals reset the device
    assign deny_is_reset = !req_from_debug;                    // [R12]

    always_comb begin
        verdict = V_NONE;
        if (take) begin
            if (req_op == OP_DEV_ERASE) begin
                // Only the debug port may wipe the whole store
                verdict = req_from_debug ? V_GRANT : V_RESET;   // [R10]
            end else if (tgt_if.reserved) begin
                verdict = deny_is_reset ? V_RESET : V_DROP;     // [R9]
            end else if (lock_write && shadow_ff != LOCK_NONE) begin
                verdict = deny_is_reset ? V_RESET : V_DROP; // [R7] [R8] [R14]
            end else if (tgt_if.lock_page && req_op == OP_ERASE) begin
                if (req_from_debug && !any_locked) begin
                    verdict = V_GRANT;                          // [R5]
                end else begin
                    verdict = deny_is_reset ? V_RESET : V_DROP; // [R5] [R6]
                end
            end else if (!tgt_if.locked) begin
                verdict = V_GRANT;                    // [R1] [R3] [R4]
            end else if (req_from_debug) begin
                verdict = V_DROP;                     // [R2] [R3] [R4]
            end else if (pc_if.locked) begin
                verdict = V_GRANT;                    // [R2] [R3] [R22]
            end else begin
                verdict = V_RESET;                    // [R2] [R4] [R11]
            end
        end
    end

    always_comb begin
        nxt_state  = state_ff;
        nxt_lock   = lock_ff;
        nxt_shadow = shadow_ff;
        case (state_ff)
            S_LOAD: begin
                nxt_lock   = lock_byte_in;                      // [R23]
                nxt_shadow = lock_byte_in;
                nxt_state  = S_RUN;
            end
            S_RUN: begin
                if (verdict == V_RESET) begin
                    nxt_state = S_HALT;                         // [R11]
                end else if (verdict == V_GRANT) begin
                    if (req_op == OP_DEV_ERASE) begin
                        nxt_lock   = LOCK_NONE;                 // [R10]
                        nxt_shadow = LOCK_NONE;
                    end else if (lock_write) begin
                        // Enforced count untouched until next reset
                        nxt_shadow = shadow_ff & req_wdata;     // [R15]
                    end else if (req_op == OP_ERASE &&
                                 tgt_if.lock_page) begin
                        nxt_shadow = LOCK_NONE;                 // [R5]
                    end
                end
            end
            S_HALT: begin
                nxt_state = S_HALT;   // Waits for the device reset
            end
            default: begin
                nxt_state = S_LOAD;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff  <= S_LOAD;
            lock_ff   <= LOCK_NONE;
            shadow_ff <= LOCK_NONE;
            grant_ff  <= 1'b0;
            drop_ff   <= 1'b0;
            reset_ff  <= 1'b0;
            ready_ff  <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            lock_ff   <= nxt_lock;
            shadow_ff <= nxt_shadow;
            grant_ff  <= (verdict == V_GRANT);
            drop_ff   <= (verdict == V_DROP);
            reset_ff  <= (verdict == V_RESET);
            ready_ff  <= (nxt_state == S_RUN);
        end
    end

    reset_source_keeper u_rsrc (
        .ref_clk  (ref_clk),
        .por_rst  (por_rst),
        .rst      (rst),
        .set_err  (reset_ff),
        .err_flag (flash_error_flag)
    );

    // Interrupts arriving during a flash operation wait here
    logic [IRQ_N-1:0]    pend_ff, nxt_pend;
    logic                irq_req_ff, nxt_irq_req;
    logic [IRQ_ID_W-1:0] irq_id_ff, nxt_irq_id;

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_N; gi = gi + 1) begin : g_pend
            // A new event beats the acknowledge in the same cycle
            assign nxt_pend[gi] = irq_raw[gi] | (pend_ff[gi] &
                ~(irq_ack && irq_req_ff &&
                  irq_id_ff == IRQ_ID_W'(gi)));                 // [R16]
        end
    endgenerate

    always_comb begin
        nxt_irq_id = irq_id_ff;
        for (int i = IRQ_N - 1; i >= 0; i--) begin
            if (nxt_pend[i]) begin
                nxt_irq_id = IRQ_ID_W'(i);   // Lowest index wins
            end
        end
        nxt_irq_req = (|nxt_pend) && irq_enable && !flash_busy; // [R16]
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_ff    <= '0;
            irq_req_ff <= 1'b0;
            irq_id_ff  <= '0;
        end else begin
            pend_ff    <= nxt_pend;
            irq_req_ff <= nxt_irq_req;
            irq_id_ff  <= nxt_irq_id;
        end
    end

    assign ready           = ready_ff;
    assign grant           = grant_ff;
    assign drop            = drop_ff;
    assign flash_reset_req = reset_ff;
    assign lock_pages      = lock_ff;
    assign lock_shadow     = shadow_ff;
    assign irq_req         = irq_req_ff;
    assign irq_id          = irq_id_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_unlocked_grant: assert property (                          // [R1]
        (take && req_op != OP_DEV_ERASE && !tgt_if.reserved &&
         !tgt_if.lock_page && !tgt_if.locked) |=> grant_ff)
        else $error("unlocked page access not granted");

    a_locked_fw_reset: assert property (                         // [R2]
        (take && !req_from_debug && req_op != OP_DEV_ERASE &&
         !tgt_if.lock_page && !tgt_if.reserved && tgt_if.locked &&
         !pc_if.locked) |=> reset_ff)
        else $error("locked page from unlocked code not reset");

    a_lock_page_free: assert property (                          // [R3]
        (take && tgt_if.lock_page && !any_locked &&
         (req_op == OP_READ || (req_op == OP_WRITE &&
          shadow_ff == LOCK_NONE))) |=> grant_ff)
        else $error("free lock page access refused");

    a_lock_erase_fw: assert property (                           // [R5]
        (take && !req_from_debug && req_op == OP_ERASE &&
         tgt_if.lock_page) |=> reset_ff)
        else $error("firmware lock page erase not reset");

    a_lock_erase_dbg: assert property (                          // [R6]
        (take && req_from_debug && req_op == OP_ERASE &&
         tgt_if.lock_page && any_locked) |=> drop_ff && !grant_ff)
        else $error("debug erase of locked lock page not dropped");

    a_reserved_block: assert property (                          // [R9]
        (take && req_op != OP_DEV_ERASE && tgt_if.reserved)
        |=> !grant_ff && (drop_ff || reset_ff))
        else $error("reserved area access granted");

    a_dev_erase_wipe: assert property (                          // [R10]
        (take && req_from_debug && req_op == OP_DEV_ERASE)
        |=> grant_ff && lock_ff == 8'hFF && shadow_ff == 8'hFF)
        else $error("device erase left locks in place");

    a_halt_on_error: assert property (                           // [R11]
        reset_ff |-> (!ready_ff && !grant_ff)[*3])
        else $error("checker kept running after flash error");

    a_debug_no_reset: assert property (                          // [R12]
        (take && req_from_debug) |=> !reset_ff)
        else $error("debug request caused device reset");

    a_lock_frozen: assert property (                             // [R14]
        (take && lock_write && shadow_ff != LOCK_NONE)
        |=> $stable(shadow_ff))
        else $error("written lock byte changed");

    a_lock_deferred: assert property (                           // [R15]
        (state_ff == S_RUN && !(take && req_op == OP_DEV_ERASE))
        |=> $stable(lock_ff))
        else $error("enforced locks changed before reset");

    a_irq_held: assert property (                                // [R16]
        flash_busy |=> !irq_req_ff)
        else $error("interrupt raised during flash operation");

    a_lock_read_dbg: assert property (                           // [R4]
        (take && req_from_debug && req_op == OP_READ &&
         req_addr == LOCK_ADDR && any_locked) |=> drop_ff)
        else $error("locked lock byte read by debug");

    a_lock_rewrite: assert property (                       // [R7] [R8]
        (take && lock_write && shadow_ff != LOCK_NONE)
        |=> !grant_ff && (drop_ff || reset_ff))
        else $error("written lock byte rewritten");

    a_lock_page_tied: assert property (                          // [R13]
        (tgt_if.lock_page && any_locked) |-> tgt_if.locked)
        else $error("lock page open while pages locked");

    a_page_count: assert property (                              // [R19]
        (!tgt_if.lock_page && !tgt_if.reserved) |->
        tgt_if.locked == (({5'h00, req_addr[ADDR_W-1:PAGE_LSB]} +
                           {1'b0, lock_ff}) < 9'h0FF))
        else $error("locked page count wrong");

    a_code_page_grant: assert property (                         // [R22]
        (take && !req_from_debug && req_op != OP_DEV_ERASE &&
         !tgt_if.reserved && !tgt_if.lock_page && pc_if.locked)
        |=> grant_ff)
        else $error("locked code refused ordinary page");

    a_load_at_reset: assert property (                           // [R23]
        (state_ff == S_LOAD && !rst) |=>
        (lock_ff == $past(lock_byte_in) && shadow_ff == lock_ff))
        else $error("lock byte not loaded after reset");

    c_locked_code_grant: cover property (
        take && !req_from_debug && tgt_if.locked && pc_if.locked);
    c_debug_drop: cover property (drop_ff);
    c_fw_reset: cover property (reset_ff);
    c_dev_erase: cover property (
        take && req_from_debug && req_op == OP_DEV_ERASE && any_locked);

endmodule : flash_page_security_checker

// File: verilog/flash_sec_pkg.sv
// Constants, encodings and types for the flash page security checker.
// Assumes an 8 kB program store in 512-byte pages, top page reserved.
// Contract
// (R1) Unlocked ordinary pages open to every requester
// (R2) Locked pages: debug dropped, unlocked code resets
// (R3) Lock page read/write free until anything locks
// (R4) Lock byte read follows the lock page
// (R5) Unlocked lock page erase: debug only
// (R6) Locked lock page: only device erase clears
// (R7) Locking more pages is forbidden
// (R8) Unlocking single pages is forbidden
// (R9) Reserved area forbidden to everyone
// (R10) Debug device erase wipes all locks
// (R11) Firmware violation resets, error flag reads one
// (R12) Debug violations dropped, never reset
// (R13) Any lock also locks the lock page
// (R14) Written lock byte stays frozen
// (R15) Firmware lock write waits for next reset
// (R16) Interrupts held during flash busy
// (R17) Firmware masks interrupts around store_write_enable
// (R18) Firmware assigns reset source register directly
// (R19) Locked page count is complement of byte
// (R20) Lock byte is last user byte
// (R21) Reserved area is top 512 bytes
// (R22) Decide from target page and code page
// (R23) Count loaded at reset, flag survives reset
package flash_sec_pkg;

    localparam int          ADDR_W    = 13;
    localparam int          PAGE_LSB  = 9;      // 512-byte pages
    localparam int          PAGE_W    = 4;
    localparam logic [12:0] LOCK_ADDR = 13'h1DFF;
    localparam logic [3:0]  LOCK_PAGE = 4'hE;
    localparam logic [3:0]  RSV_PAGE  = 4'hF;   // 0x1E00 to 0x1FFF
    localparam logic [7:0]  LOCK_NONE = 8'hFF;
    localparam int          IRQ_N     = 8;
    localparam int          IRQ_ID_W  = 3;
    localparam int          SWE_BIT   = 0;      // store_write_enable position

    typedef enum logic [1:0] {
        OP_READ      = 2'b00,
        OP_WRITE     = 2'b01,
        OP_ERASE     = 2'b10,
        OP_DEV_ERASE = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        V_NONE  = 2'b00,
        V_GRANT = 2'b01,
        V_DROP  = 2'b10,
        V_RESET = 2'b11
    } verdict_t;

    typedef enum logic [1:0] {
        S_LOAD = 2'b00,
        S_RUN  = 2'b01,
        S_HALT = 2'b10
    } state_t;

endpackage : flash_sec_pkg

// File: verilog/page_class_if.sv
// Carrier between the checker and its page classifiers.
// The user side drives the address and the enforced lock byte.
`timescale 1ns/1ps
interface page_class_if;
    import flash_sec_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        lock_val;
    logic              locked;
    logic              lock_page;
    logic              reserved;

    modport classifier (input addr, input lock_val,
                        output locked, output lock_page, output reserved);
    modport user       (output addr, output lock_val,
                        input locked, input lock_page, input reserved);
endinterface : page_class_if

// File: verilog/page_classifier.sv
// Classifies one address against the enforced lock byte.
// Purely combinational; the caller registers the verdict.
`timescale 1ns/1ps
module page_classifier (
    page_class_if.classifier pc     // Address in, page class out
);
    import flash_sec_pkg::*;

    logic [PAGE_W-1:0] page;
    logic [7:0]        count;
    logic              any_lock;

    assign page     = pc.addr[ADDR_W-1:PAGE_LSB];       // [R22]
    assign count    = ~pc.lock_val;                     // [R19]
    assign any_lock = (count != 8'h00);
    assign pc.lock_page = (page == LOCK_PAGE);          // [R20]
    assign pc.reserved  = (page == RSV_PAGE);           // [R21]
    // Lock page follows any other lock, not its own count
    assign pc.locked = (page == LOCK_PAGE) ? any_lock :         // [R13]
                       ({4'h0, page} < count);                  // [R19]

endmodule : page_classifier

// File: verilog/reset_source_keeper.sv
// Flash error flag of the reset source register.
// Runs on power-on reset only so the flag outlives the reset it caused;
// rst must be held for at least two clock edges.
`timescale 1ns/1ps
module reset_source_keeper (
    input  wire logic ref_clk,     // System clock
    input  wire logic por_rst,     // Power-on reset, async, high
    input  wire logic rst,         // Device reset level
    input  wire logic set_err,     // Firmware violation pulse
    output logic      err_flag     // Flash error flag
);
    logic cause_ff, nxt_cause;
    logic flag_ff, nxt_flag;
    logic rst_d_ff;

    always_comb begin
        nxt_cause = cause_ff;
        nxt_flag  = flag_ff;
        if (rst && !rst_d_ff) begin
            // A violation in the reset's own cycle still counts
            nxt_flag  = cause_ff | set_err;     // [R11] [R23]
            nxt_cause = 1'b0;
        end else if (set_err) begin
            nxt_cause = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge por_rst) begin
        if (por_rst) begin
            cause_ff <= 1'b0;
            flag_ff  <= 1'b0;
            rst_d_ff <= 1'b0;
        end else begin
            cause_ff <= nxt_cause;
            flag_ff  <= nxt_flag;
            rst_d_ff <= rst;
        end
    end

    assign err_flag = flag_ff;

    a_flag_follows_cause: assert property (       // [R11]
        @(posedge ref_clk) disable iff (por_rst)
        (rst && !rst_d_ff && cause_ff && !set_err) |=> flag_ff)
        else $error("flash error flag lost across reset");

endmodule : reset_source_keeper
